// ### ssrfc_pkg.sv
// shared constants and types for the start, restart and fire-mode control block
// assumes a 200 MHz core clock and a 32-bit APB register bus
package ssrfc_pkg;

  // ==========================================================================
  // clock and time base
  localparam int unsigned CLK_FREQ_HZ        = 200_000_000;
  localparam int unsigned SEC_PER_TICK       = 1;
  localparam int unsigned RESTART_INTERVAL_S = 20;
  localparam int unsigned RESTART_TICKS      = RESTART_INTERVAL_S / SEC_PER_TICK;
  localparam int unsigned MAX_ATTEMPTS       = 5;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_START_CFG = 8'h00;
  localparam logic [7:0] OFS_FIRE_CFG  = 8'h04;
  localparam logic [7:0] OFS_VF_CFG    = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0C;
  localparam logic [7:0] OFS_COMMAND   = 8'h10;

  // field positions
  localparam int unsigned FLD_FIRE_POL   = 0;
  localparam int unsigned FLD_FIRE_TYPE  = 1;
  localparam int unsigned FLD_DIN_FUNC   = 8;
  localparam int unsigned FLD_VF_VOLT    = 16;
  localparam int unsigned FLD_ST_CNT     = 3;
  localparam int unsigned FLD_ST_RUN     = 8;
  localparam int unsigned FLD_ST_FAULT   = 9;
  localparam int unsigned FLD_ST_FIRE    = 10;
  localparam int unsigned FLD_ST_ARMED   = 11;
  localparam int unsigned FLD_CMD_FRESET = 0;
  localparam int unsigned FLD_CMD_FDIS   = 1;

  // start mode codes: edge, auto start, then restart with 1..5 attempts
  localparam logic [2:0] MODE_EDGE      = 3'h0;
  localparam logic [2:0] MODE_AUTO      = 3'h1;
  localparam logic [2:0] MODE_RESTART_1 = 3'h2;
  localparam logic [2:0] MODE_RESTART_5 = 3'h6;

  // input functions that carry fire mode
  localparam logic [4:0] DIN_FIRE_A = 5'h0F;
  localparam logic [4:0] DIN_FIRE_B = 5'h10;
  localparam logic [4:0] DIN_FIRE_C = 5'h11;

  // reset values
  localparam logic [2:0]  RST_START_MODE = 3'h0;
  localparam logic        RST_FIRE_POL   = 1'b0;
  localparam logic        RST_FIRE_TYPE  = 1'b0;
  localparam logic [4:0]  RST_DIN_FUNC   = 5'h00;
  localparam logic [15:0] RST_VF_FREQ    = 16'h0000;
  localparam logic [15:0] RST_VF_VOLT    = 16'h0000;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_RUN  = 3'b001,
    ST_WAIT = 3'b010,
    ST_TRIP = 3'b011,
    ST_LOCK = 3'b100
  } ssrfc_state_type;

  typedef struct packed
  {
    logic [2:0]  startMode;
    logic        firePol;
    logic        fireType;
    logic [4:0]  dinFunc;
    logic [15:0] vfFreq;
    logic [15:0] vfVolt;
  } ssrfc_cfg_type;

endpackage

// ### ssrfc_sec_tick.sv
// one-second time base: a single-cycle tick every CYCLES core clocks
// assumes the caller restarts it with clear when a fresh interval begins
`timescale 1ns/1ps
`default_nettype none
module ssrfc_sec_tick
#(
  parameter int unsigned CYCLES = 200_000_000
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // control and tick
  input  wire logic clear,
  output var  logic tick_q
);

  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  logic [W-1:0] cnt_q;

  // ==========================================================================
  // prescaler; clear aligns the interval so the first tick is a full second away
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (clear)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (cnt_q == W'(CYCLES - 1))
    begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + W'(1);
      tick_q <= 1'b0;
    end
  end

endmodule // ssrfc_sec_tick
`default_nettype wire

// ### ssrfc_start_ctrl.sv
// start mode, automatic restart and fire mode control with an APB register file
// assumes reset_n is the power-on reset; run and fire contacts are asynchronous pins
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ssrfc_start_ctrl
#(
  parameter int unsigned CYCLES_PER_SEC = ssrfc_pkg::CLK_FREQ_HZ
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // contacts and drive events
  input  wire logic        runIn,
  input  wire logic        fireIn,
  input  wire logic        tripIn,
  input  wire logic [15:0] outFreq,
  // drive control outputs
  output var  logic        driveRun_q,
  output var  logic        faultLatched_q,
  output var  logic        fireMode_q,
  output var  logic        vfHit_q,
  output var  logic [15:0] vfVoltage_q
);

  // ==========================================================================
  // declarations
  ssrfc_pkg::ssrfc_cfg_type   cfg_q;
  ssrfc_pkg::ssrfc_state_type state_q;
  ssrfc_pkg::ssrfc_state_type state_d;
  logic        runMeta_q;
  logic        runSync_q;
  logic        fireMeta_q;
  logic        fireSync_q;
  logic [1:0]  settle_q;
  logic        armed_q;
  logic [2:0]  attemptCnt_q;
  logic [4:0]  waitSecs_q;
  logic        fireLatch_q;
  logic        secTick;
  logic        waitStart;
  logic        apbWrite;
  logic        apbSetup;
  logic        faultReset;
  logic        fireDisable;
  logic        fireEnabled;
  logic        fireLevel;
  logic [2:0]  attemptLimit;
  logic        retryDue;
  logic        autoMode;

  // restart attempts allowed by a start mode; zero outside the restart codes
  function automatic logic [2:0] restartLimit(input logic [2:0] mode);
    if (mode >= ssrfc_pkg::MODE_RESTART_1 && mode <= ssrfc_pkg::MODE_RESTART_5)
      restartLimit = mode - 3'h1;
    else
      restartLimit = 3'h0;
  endfunction

  // input functions that include fire mode
  function automatic logic isFireFunc(input logic [4:0] fn);
    isFireFunc = (fn == ssrfc_pkg::DIN_FIRE_A) || (fn == ssrfc_pkg::DIN_FIRE_B)
              || (fn == ssrfc_pkg::DIN_FIRE_C);
  endfunction

  // ==========================================================================
  // pin synchronisers; settle_q hides the reset value, which would look like an open contact
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      runMeta_q  <= 1'b0;
      runSync_q  <= 1'b0;
      fireMeta_q <= 1'b0;
      fireSync_q <= 1'b0;
      settle_q   <= 2'h0;
    end
    else
    begin
      runMeta_q  <= runIn;
      runSync_q  <= runMeta_q;
      fireMeta_q <= fireIn;
      fireSync_q <= fireMeta_q;
      settle_q   <= settle_q + {1'b0, !settle_q[1]};
    end
  end

  // ==========================================================================
  // apb slave: one wait-free access phase, read data captured in setup
  assign apbSetup    = psel && !penable;
  assign apbWrite    = psel && penable && pready && pwrite;
  assign faultReset  = apbWrite && (paddr == ssrfc_pkg::OFS_COMMAND)
                    && pwdata[ssrfc_pkg::FLD_CMD_FRESET];
  assign fireDisable = apbWrite && (paddr == ssrfc_pkg::OFS_COMMAND)
                    && pwdata[ssrfc_pkg::FLD_CMD_FDIS];

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apbSetup;
      pslverr <= apbSetup && !(paddr == ssrfc_pkg::OFS_START_CFG
              || paddr == ssrfc_pkg::OFS_FIRE_CFG || paddr == ssrfc_pkg::OFS_VF_CFG
              || paddr == ssrfc_pkg::OFS_STATUS || paddr == ssrfc_pkg::OFS_COMMAND);
      prdata  <= 32'h0000_0000;
      if (apbSetup && !pwrite)
      begin
        case (paddr)
          ssrfc_pkg::OFS_START_CFG: prdata[2:0] <= cfg_q.startMode;
          ssrfc_pkg::OFS_FIRE_CFG:
          begin
            prdata[ssrfc_pkg::FLD_FIRE_POL]                       <= cfg_q.firePol;
            prdata[ssrfc_pkg::FLD_FIRE_TYPE]                      <= cfg_q.fireType;
            prdata[ssrfc_pkg::FLD_DIN_FUNC +: 5]                  <= cfg_q.dinFunc;
          end
          ssrfc_pkg::OFS_VF_CFG:    prdata <= {cfg_q.vfVolt, cfg_q.vfFreq};
          ssrfc_pkg::OFS_STATUS:
          begin
            prdata[2:0]                           <= state_q;
            prdata[ssrfc_pkg::FLD_ST_CNT +: 3]    <= attemptCnt_q;
            prdata[ssrfc_pkg::FLD_ST_RUN]         <= driveRun_q;
            prdata[ssrfc_pkg::FLD_ST_FAULT]       <= faultLatched_q;
            prdata[ssrfc_pkg::FLD_ST_FIRE]        <= fireMode_q;
            prdata[ssrfc_pkg::FLD_ST_ARMED]       <= armed_q;
          end
          default:                  prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // configuration registers; writes land at the access edge only
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q.startMode <= ssrfc_pkg::RST_START_MODE;
      cfg_q.firePol   <= ssrfc_pkg::RST_FIRE_POL;
      cfg_q.fireType  <= ssrfc_pkg::RST_FIRE_TYPE;
      cfg_q.dinFunc   <= ssrfc_pkg::RST_DIN_FUNC;
      cfg_q.vfFreq    <= ssrfc_pkg::RST_VF_FREQ;
      cfg_q.vfVolt    <= ssrfc_pkg::RST_VF_VOLT;
    end
    else if (apbWrite)
    begin
      case (paddr)
        ssrfc_pkg::OFS_START_CFG: cfg_q.startMode <= pwdata[2:0];
        ssrfc_pkg::OFS_FIRE_CFG:
        begin
          cfg_q.firePol  <= pwdata[ssrfc_pkg::FLD_FIRE_POL];
          cfg_q.fireType <= pwdata[ssrfc_pkg::FLD_FIRE_TYPE];
          cfg_q.dinFunc  <= pwdata[ssrfc_pkg::FLD_DIN_FUNC +: 5];
        end
        ssrfc_pkg::OFS_VF_CFG:
        begin
          cfg_q.vfFreq <= pwdata[15:0];
          cfg_q.vfVolt <= pwdata[ssrfc_pkg::FLD_VF_VOLT +: 16];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // start and restart sequencing
  assign autoMode     = (cfg_q.startMode == ssrfc_pkg::MODE_AUTO);
  assign attemptLimit = restartLimit(cfg_q.startMode);
  assign retryDue     = (waitSecs_q == 5'(ssrfc_pkg::RESTART_TICKS));
  assign waitStart    = (state_q != ssrfc_pkg::ST_WAIT) && (state_d == ssrfc_pkg::ST_WAIT);

  ssrfc_sec_tick #(.CYCLES(CYCLES_PER_SEC)) u_tick
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clear    (waitStart),
    .tick_q   (secTick)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ssrfc_pkg::ST_IDLE:
        if (runSync_q && (autoMode || armed_q))
          state_d = ssrfc_pkg::ST_RUN;
      ssrfc_pkg::ST_RUN:
        if (tripIn)
        begin
          if (attemptLimit == 3'h0)
            state_d = ssrfc_pkg::ST_TRIP;
          else if (attemptCnt_q >= attemptLimit)
            state_d = ssrfc_pkg::ST_LOCK;
          else
            state_d = ssrfc_pkg::ST_WAIT;
        end
        else if (!runSync_q)
          state_d = ssrfc_pkg::ST_IDLE;
      ssrfc_pkg::ST_WAIT:
        if (!runSync_q)
          state_d = ssrfc_pkg::ST_IDLE;
        else if (retryDue)
          state_d = ssrfc_pkg::ST_RUN;
      ssrfc_pkg::ST_TRIP, ssrfc_pkg::ST_LOCK:
        if (faultReset)
          state_d = ssrfc_pkg::ST_IDLE;
      default:
        state_d = ssrfc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= ssrfc_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // edge arming: a reset or fault reset disarms, an open contact rearms
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      armed_q <= 1'b0;
    else if (faultReset)
      armed_q <= 1'b0;
    else if (!runSync_q && settle_q[1])
      armed_q <= 1'b1;
    else if (state_q == ssrfc_pkg::ST_RUN)
      armed_q <= 1'b0;
  end

  // attempt counter survives fault resets; only power-on clears it
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      attemptCnt_q <= 3'h0;
    else if (state_q == ssrfc_pkg::ST_WAIT && state_d == ssrfc_pkg::ST_RUN)
      attemptCnt_q <= attemptCnt_q + 3'h1;
  end

  // seconds spent waiting for the next retry
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      waitSecs_q <= 5'h00;
    else if (state_q != ssrfc_pkg::ST_WAIT)
      waitSecs_q <= 5'h00;
    else if (secTick && !retryDue)
      waitSecs_q <= waitSecs_q + 5'h01;
  end

  // ==========================================================================
  // fire mode; the latch set wins over a same-cycle disable
  assign fireEnabled = isFireFunc(cfg_q.dinFunc);
  assign fireLevel   = cfg_q.firePol ? fireSync_q : !fireSync_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      fireLatch_q <= 1'b0;
    else if (fireEnabled && cfg_q.fireType && fireLevel)
      fireLatch_q <= 1'b1;
    else if (fireDisable || !fireEnabled || !cfg_q.fireType)
      fireLatch_q <= 1'b0;
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      driveRun_q     <= 1'b0;
      faultLatched_q <= 1'b0;
      fireMode_q     <= 1'b0;
      vfHit_q        <= 1'b0;
      vfVoltage_q    <= 16'h0000;
    end
    else
    begin
      driveRun_q     <= (state_d == ssrfc_pkg::ST_RUN);
      faultLatched_q <= (state_d == ssrfc_pkg::ST_LOCK);
      fireMode_q     <= fireEnabled && (cfg_q.fireType ? (fireLatch_q || fireLevel)
                                                        : fireLevel);
      vfHit_q        <= (outFreq == cfg_q.vfFreq);
      vfVoltage_q    <= (outFreq == cfg_q.vfFreq) ? cfg_q.vfVolt : 16'h0000;
    end
  end

  // ==========================================================================
  // checks
  chk_edge_no_start: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ssrfc_pkg::ST_IDLE && !autoMode && !armed_q |=> state_q != ssrfc_pkg::ST_RUN)
    else $error("edge mode started without a fresh closure");

  chk_auto_start: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ssrfc_pkg::ST_IDLE && autoMode && runSync_q |=> driveRun_q)
    else $error("auto mode did not start on closed run contact");

  chk_retry_spacing: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ssrfc_pkg::ST_WAIT ##1 state_q == ssrfc_pkg::ST_RUN
    |-> $past(waitSecs_q) == 5'(ssrfc_pkg::RESTART_TICKS))
    else $error("retry not spaced by the restart interval");

  chk_attempt_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
    attemptCnt_q <= 3'(ssrfc_pkg::MAX_ATTEMPTS))
    else $error("attempt count beyond maximum");

  chk_lockout_entry: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ssrfc_pkg::ST_RUN && tripIn && attemptLimit != 3'h0
    && attemptCnt_q >= attemptLimit |=> faultLatched_q ##1 (faultLatched_q || $past(faultReset)))
    else $error("final failed attempt did not latch the fault");

  chk_lock_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ssrfc_pkg::ST_LOCK && !faultReset |=> state_q == ssrfc_pkg::ST_LOCK)
    else $error("fault latch released without manual reset");

  chk_count_kept: assert property (@(posedge core_clk) disable iff (!reset_n)
    faultReset && state_q != ssrfc_pkg::ST_WAIT |=> attemptCnt_q == $past(attemptCnt_q))
    else $error("fault reset altered the attempt count");

  chk_fire_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    !fireEnabled |=> !fireMode_q)
    else $error("fire mode active with a non-fire input function");

  chk_fire_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    fireEnabled && !cfg_q.fireType
    |=> fireMode_q == ($past(cfg_q.firePol) == $past(fireSync_q)))
    else $error("maintained fire mode does not follow the polarised input");

  chk_fire_latched: assert property (@(posedge core_clk) disable iff (!reset_n)
    fireLatch_q && fireEnabled && cfg_q.fireType && !fireDisable ##1 fireEnabled
    && cfg_q.fireType |-> fireMode_q)
    else $error("momentary fire mode dropped while latched");

  chk_vf_point: assert property (@(posedge core_clk) disable iff (!reset_n)
    outFreq == cfg_q.vfFreq |=> vfHit_q && vfVoltage_q == $past(cfg_q.vfVolt))
    else $error("adjustment voltage not applied at the adjustment point");

  chk_no_retry_plain: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ssrfc_pkg::ST_RUN && tripIn && attemptLimit == 3'h0
    |=> state_q == ssrfc_pkg::ST_TRIP)
    else $error("retry scheduled outside restart modes");

  cov_auto_start: cover property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ssrfc_pkg::ST_IDLE && autoMode ##1 driveRun_q);
  cov_retry: cover property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ssrfc_pkg::ST_WAIT ##1 state_q == ssrfc_pkg::ST_RUN);
  cov_lockout: cover property (@(posedge core_clk) disable iff (!reset_n)
    $rose(faultLatched_q));
  cov_fire_latch: cover property (@(posedge core_clk) disable iff (!reset_n)
    $rose(fireLatch_q));

endmodule // ssrfc_start_ctrl
`default_nettype wire

// ### ssrfc_contact_model.sv
// machine side model of the run and fire contacts
// assumes the bench asks for contact levels; high means the contact is closed
`timescale 1ns/1ps
`default_nettype none
module ssrfc_contact_model
(
  // clock
  input  wire logic core_clk,
  // wanted contact levels
  input  wire logic wantRun,
  input  wire logic wantFire,
  // contact pins
  output var  logic runIn,
  output var  logic fireIn
);
  // ==========================================================================
  // contact state
  // contacts move just after an edge, as a relay driven by the same clock would
  initial
  begin
    runIn  = 1'b1;
    fireIn = 1'b0;
  end
  always @(posedge core_clk)
  begin
    runIn  <= wantRun;
    fireIn <= wantFire; // closed is high whatever the polarity setting
  end
endmodule // ssrfc_contact_model
`default_nettype wire

// ### tb.sv
// self-checking bench for the start, restart and fire-mode control block
// assumes the time base is shortened to CPS core cycles per second
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================================
  // setup
  localparam int unsigned CPS   = 10;
  localparam int unsigned GAP   = ssrfc_pkg::RESTART_INTERVAL_S * CPS;
  localparam int unsigned LIMIT = 20000;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        tripIn   = 1'b0;
  logic [15:0] outFreq  = 16'h0000;
  logic        wantRun  = 1'b1;
  logic        wantFire = 1'b0;
  logic [31:0] prdata, rdq;
  logic        pready, pslverr, rde, runIn, fireIn;
  logic        driveRun_q, faultLatched_q, fireMode_q, vfHit_q;
  logic [15:0] vfVoltage_q;
  int          badCount = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #2.5 core_clk = ~core_clk;

  ssrfc_start_ctrl #(.CYCLES_PER_SEC(CPS)) dut
  (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .runIn(runIn), .fireIn(fireIn),
    .tripIn(tripIn), .outFreq(outFreq), .driveRun_q(driveRun_q),
    .faultLatched_q(faultLatched_q), .fireMode_q(fireMode_q),
    .vfHit_q(vfHit_q), .vfVoltage_q(vfVoltage_q)
  );

  ssrfc_contact_model contacts
  (
    .core_clk(core_clk), .wantRun(wantRun), .wantFire(wantFire),
    .runIn(runIn), .fireIn(fireIn)
  );

  // ==========================================================================
  // helpers
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    chk32(n, {31'h0, e}, {31'h0, g});
  endtask

  // one apb transfer; results are taken at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    chk1("pready", 1'b1, pready);
    rdq = prdata;
    rde = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // checks happen at the falling edge, clear of the updates of the rising edge
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic waitRun(input logic e, input int m);
    int n;
    n = 0;
    while (driveRun_q !== e && n < m)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic trip();
    @(posedge core_clk);
    tripIn <= 1'b1;
    @(posedge core_clk);
    tripIn <= 1'b0;
  endtask

  task automatic attempts(input logic [31:0] e);
    rd(ssrfc_pkg::OFS_STATUS);
    chk32("attempts", e, (rdq >> ssrfc_pkg::FLD_ST_CNT) & 32'h7);
  endtask

  // ==========================================================================
  // scenarios
  // power-on with the run contact already closed
  task automatic t_power();
    @(posedge core_clk);
    reset_n <= 1'b0;
    wantRun <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    cycles(8);
    chk1("runAtReset", 1'b0, driveRun_q);
    attempts(32'h0);
    rd(ssrfc_pkg::OFS_START_CFG);
    chk32("startCfg", 32'h0, rdq);
    rd(ssrfc_pkg::OFS_FIRE_CFG);
    chk32("fireCfg", 32'h0, rdq);
    rd(ssrfc_pkg::OFS_VF_CFG);
    chk32("vfCfg", 32'h0, rdq);
    rd(8'h20);
    chk1("unmappedErr", 1'b1, rde);
    wantRun <= 1'b0;
    repeat (6) @(posedge core_clk);
    wantRun <= 1'b1;
    waitRun(1'b1, 10);
    chk1("runOnClosure", 1'b1, driveRun_q);
  endtask

  // trip in auto start: no retry, then fault reset restarts without reclosure
  task automatic t_auto();
    wr(ssrfc_pkg::OFS_START_CFG, {29'h0, ssrfc_pkg::MODE_AUTO});
    trip();
    cycles(GAP + 20);
    chk1("noRetry", 1'b0, driveRun_q);
    rd(ssrfc_pkg::OFS_STATUS);
    chk32("tripState", 32'h3, rdq & 32'h7);
    wr(ssrfc_pkg::OFS_COMMAND, 32'h1);
    waitRun(1'b1, 10);
    chk1("autoStart", 1'b1, driveRun_q);
  endtask

  // two permitted attempts, spaced by the interval, then lockout
  task automatic t_restart();
    for (int m = 0; m < 8; m++)
    begin
      wr(ssrfc_pkg::OFS_START_CFG, 32'(m));
      rd(ssrfc_pkg::OFS_START_CFG);
      chk32("modeCode", 32'(m), rdq & 32'h7);
    end
    wr(ssrfc_pkg::OFS_START_CFG, 32'h3);
    for (int i = 0; i < 2; i++)
    begin
      trip();
      cycles(GAP - 10);
      chk1("earlyRetry", 1'b0, driveRun_q);
      waitRun(1'b1, 20);
      chk1("retry", 1'b1, driveRun_q);
      attempts(32'(i + 1));
    end
    trip();
    cycles(GAP + 20);
    chk1("lockout", 1'b1, faultLatched_q);
    chk1("lockStop", 1'b0, driveRun_q);
    wr(ssrfc_pkg::OFS_COMMAND, 32'h1);
    cycles(2);
    chk1("faultClear", 1'b0, faultLatched_q);
    attempts(32'h2);
  endtask

  // maintained fire input over every fire function and polarity
  task automatic t_fire();
    wr(ssrfc_pkg::OFS_FIRE_CFG, 32'h0);
    cycles(6);
    chk1("fireNoFunc", 1'b0, fireMode_q);
    for (int f = 15; f < 18; f++)
      for (int p = 0; p < 2; p++)
        for (int l = 0; l < 2; l++)
        begin
          wr(ssrfc_pkg::OFS_FIRE_CFG, 32'((f << 8) | p));
          wantFire <= l[0];
          cycles(6);
          chk1("fireMaint", l == p, fireMode_q);
        end
    wr(ssrfc_pkg::OFS_FIRE_CFG, 32'h0F03);
    wantFire <= 1'b1;
    repeat (6) @(posedge core_clk);
    wantFire <= 1'b0;
    cycles(6);
    chk1("fireLatch", 1'b1, fireMode_q);
    wr(ssrfc_pkg::OFS_COMMAND, 32'h2);
    cycles(3);
    chk1("fireDisable", 1'b0, fireMode_q);
  endtask

  // adjustment voltage applied only at the adjustment frequency point
  task automatic t_vf();
    wr(ssrfc_pkg::OFS_VF_CFG, 32'h0456_0123);
    outFreq <= 16'h0123;
    cycles(3);
    chk1("vfHit", 1'b1, vfHit_q);
    chk32("vfVolt", 32'h0456, {16'h0, vfVoltage_q});
    @(posedge core_clk);
    outFreq <= 16'h0124;
    cycles(3);
    chk1("vfMiss", 1'b0, vfHit_q);
    chk32("vfVoltOff", 32'h0, {16'h0, vfVoltage_q});
  endtask

  // ==========================================================================
  // verdict, timeout and main sequence
  task automatic testDone();
    if (badCount == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      badCount++;
      testDone();
    end
  end

  initial
  begin
    t_power();
    t_auto();
    t_restart();
    t_fire();
    t_vf();
    t_power(); // second power-on clears the attempt count
    testDone();
  end
endmodule // tb
`default_nettype wire
